/* File: common/usb_status_pkg.sv */
// Shared constants and types for the device status and fault reporting block
package usb_status_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DEV_STATUS = 8'hfe;
  localparam logic [7:0] CMD_FAULT      = 8'hff;

  // ----------------------------------------------------------------
  // Device status byte layout
  // ----------------------------------------------------------------
  localparam int BIT_CONNECT     = 0;
  localparam int BIT_CONN_CHANGE = 1;
  localparam int BIT_SLEEP       = 2;
  localparam int BIT_SLEEP_CHG   = 3;
  localparam int BIT_BUS_RESET   = 4;

  // ----------------------------------------------------------------
  // Fault byte layout
  // ----------------------------------------------------------------
  localparam int FAULT_CODE_W     = 4;
  localparam int FAULT_ACTIVE_BIT = 4;
  localparam int RESERVED_W       = 3;

  typedef enum logic [3:0] {
    FAULT_NONE       = 4'h0,
    FAULT_PID_ENC    = 4'h1,
    FAULT_PID_UNK    = 4'h2,
    FAULT_SEQUENCE   = 4'h3,
    FAULT_TOKEN_CRC  = 4'h4,
    FAULT_DATA_CRC   = 4'h5,
    FAULT_TIMEOUT    = 4'h6,
    FAULT_BABBLE     = 4'h7,
    FAULT_EOP        = 4'h8,
    FAULT_NAK        = 4'h9,
    FAULT_STALL_SENT = 4'ha,
    FAULT_OVERRUN    = 4'hb,
    FAULT_ISO_EMPTY  = 4'hc,
    FAULT_BITSTUFF   = 4'hd,
    FAULT_SYNC       = 4'he,
    FAULT_TOGGLE     = 4'hf
  } fault_code_t;

  localparam fault_code_t FAULT_RESET = FAULT_NONE;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ    = 20;
  localparam int IDLE_TIME_US    = 3000;
  localparam int WAKE_TIME_US    = 2000;
  localparam int IDLE_CYCLES_DEF = IDLE_TIME_US * CLK_FREQ_MHZ;
  localparam int WAKE_CYCLES_DEF = WAKE_TIME_US * CLK_FREQ_MHZ;
  localparam int TIMER_W         = 17;

  typedef enum logic [0:0] {
    WAKE_IDLE  = 1'b0,
    WAKE_DRIVE = 1'b1
  } wake_state_t;

endpackage

/* File: design/line_idle_timer.sv */
// Upstream line activity synchroniser and idle timer
`timescale 1ns/100ps
module line_idle_timer
  import usb_status_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic line_activity,
  output logic      activity_sync,
  output logic      idle_expired
);

  logic               sync_stage;
  logic [TIMER_W-1:0] idle_count;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_stage    <= 1'b0;
      activity_sync <= 1'b0;
    end else begin
      sync_stage    <= line_activity;
      activity_sync <= sync_stage;
    end
  end

  // ----------------------------------------------------------------
  // Idle counter, saturating
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_count <= '0;
    end else if (activity_sync) begin
      idle_count <= '0;
    end else if (idle_count != TIMER_W'(IDLE_CYCLES)) begin
      idle_count <= idle_count + TIMER_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_expired <= 1'b0;
    end else begin
      idle_expired <= !activity_sync && (idle_count == TIMER_W'(IDLE_CYCLES));
    end
  end

  chk_idle_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    activity_sync |=> !idle_expired)
    else $error("idle flag survived line activity");

endmodule

/* File: design/fault_recorder.sv */
// Last fault code and fault-active flag
`timescale 1ns/100ps
module fault_recorder
  import usb_status_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              fault_strobe,
  input  wire logic [3:0]        fault_in,
  input  wire logic              fault_read,
  output fault_code_t            fault_code,
  output logic                   fault_active
);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fault_code <= FAULT_RESET;
    end else if (fault_strobe) begin
      fault_code <= fault_code_t'(fault_in);
    end
  end

  // New fault wins over a read in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fault_active <= 1'b0;
    end else if (fault_strobe) begin
      fault_active <= 1'b1;
    end else if (fault_read) begin
      fault_active <= 1'b0;
    end
  end

  chk_fault_set: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_strobe |=> fault_active && fault_code == $past(fault_in))
    else $error("fault not recorded");

  chk_fault_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_read && !fault_strobe |=> !fault_active)
    else $error("fault active not cleared by read");

endmodule

/* File: design/usb_sie_device_status_error.sv */
// Device status, suspend, bus reset and fault reporting for the serial engine
`timescale 1ns/100ps
module usb_sie_device_status_error
  import usb_status_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF,
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       cmd_strobe,
  input  wire logic [7:0] cmd_code,
  input  wire logic       wr_strobe,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_strobe,
  output logic      [7:0] rd_data,
  output logic            rd_done,
  input  wire logic       line_activity,
  input  wire logic       bus_reset_seen,
  input  wire logic       pullup_attached,
  input  wire logic       fault_strobe,
  input  wire logic [3:0] fault_in,
  output logic            idle_sleep_state,
  output logic            device_state_event,
  output logic            enter_default,
  output logic            wake_drive
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic [7:0]         active_cmd;
  logic               sleep_state_changed;
  logic               bus_reset_flag;
  logic               activity_sync;
  logic               idle_expired;
  logic               idle_expired_d;
  logic               connected_d;
  fault_code_t        fault_code;
  logic               fault_active;
  wake_state_t        wake_state;
  wake_state_t        next_wake_state;
  logic [TIMER_W-1:0] wake_count;

  logic status_rd;
  logic fault_rd;
  logic status_cmd;
  logic wake_request;
  logic sleep_enter;
  logic sleep_leave;
  logic reset_accept;
  logic next_sleep;

  function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] want);
    is_cmd = (code == want);
  endfunction

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  line_idle_timer #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_idle (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .line_activity (line_activity),
    .activity_sync (activity_sync),
    .idle_expired  (idle_expired)
  );

  fault_recorder u_fault (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .fault_strobe (fault_strobe),
    .fault_in     (fault_in),
    .fault_read   (fault_rd),
    .fault_code   (fault_code),
    .fault_active (fault_active)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active_cmd <= 8'h00;
    end else if (cmd_strobe) begin
      active_cmd <= cmd_code;
    end
  end

  always_comb begin
    status_cmd = cmd_strobe && is_cmd(cmd_code, CMD_DEV_STATUS);
    status_rd  = rd_strobe && is_cmd(active_cmd, CMD_DEV_STATUS);
    fault_rd   = rd_strobe && is_cmd(active_cmd, CMD_FAULT);
    wake_request = wr_strobe && is_cmd(active_cmd, CMD_DEV_STATUS)
                   && !wr_data[BIT_SLEEP] && idle_sleep_state
                   && pullup_attached;
  end

  // ----------------------------------------------------------------
  // Suspend tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_expired_d <= 1'b0;
      connected_d    <= 1'b0;
    end else begin
      idle_expired_d <= idle_expired;
      connected_d    <= pullup_attached;
    end
  end

  always_comb begin
    sleep_enter = idle_expired && !idle_expired_d && !idle_sleep_state;
    sleep_leave = idle_sleep_state
                  && (activity_sync || (connected_d && !pullup_attached));
    next_sleep  = idle_sleep_state;
    if (sleep_leave) begin
      next_sleep = 1'b0;
    end else if (sleep_enter) begin
      next_sleep = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_sleep_state <= 1'b0;
    end else begin
      idle_sleep_state <= next_sleep;
    end
  end

  // Set wins over a status read in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_state_changed <= 1'b0;
    end else if (next_sleep != idle_sleep_state) begin
      sleep_state_changed <= 1'b1;
    end else if (status_rd) begin
      sleep_state_changed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus reset
  // ----------------------------------------------------------------
  always_comb begin
    reset_accept = bus_reset_seen && pullup_attached;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_reset_flag <= 1'b0;
    end else if (reset_accept) begin
      bus_reset_flag <= 1'b1;
    end else if (status_rd) begin
      bus_reset_flag <= 1'b0;
    end
  end

  // One pulse to the endpoint, address and buffer logic
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      enter_default <= 1'b0;
    end else begin
      enter_default <= reset_accept;
    end
  end

  // ----------------------------------------------------------------
  // Device status event
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      device_state_event <= 1'b0;
    end else if ((next_sleep != idle_sleep_state) || reset_accept) begin
      device_state_event <= 1'b1;
    end else if (status_cmd) begin
      device_state_event <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Remote wake-up drive
  // ----------------------------------------------------------------
  always_comb begin
    next_wake_state = wake_state;
    case (wake_state)
      WAKE_IDLE: begin
        if (wake_request) begin
          next_wake_state = WAKE_DRIVE;
        end
      end
      WAKE_DRIVE: begin
        if (wake_count == TIMER_W'(WAKE_CYCLES - 1)) begin
          next_wake_state = WAKE_IDLE;
        end
      end
      default: begin
        next_wake_state = WAKE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wake_state <= WAKE_IDLE;
      wake_drive <= 1'b0;
    end else begin
      wake_state <= next_wake_state;
      wake_drive <= (next_wake_state == WAKE_DRIVE);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wake_count <= '0;
    end else if (wake_state == WAKE_DRIVE) begin
      wake_count <= wake_count + TIMER_W'(1);
    end else begin
      wake_count <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
      rd_done <= 1'b0;
    end else begin
      rd_done <= rd_strobe;
      if (status_rd) begin
        rd_data <= {{RESERVED_W{1'b0}}, bus_reset_flag, sleep_state_changed,
                    idle_sleep_state, 1'b0, pullup_attached};
      end else if (fault_rd) begin
        rd_data <= {{RESERVED_W{1'b0}}, fault_active, fault_code};
      end else if (rd_strobe) begin
        rd_data <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  chk_wake_start: assert property (
    wake_request && !wake_drive |=> wake_drive ##0 wake_state == WAKE_DRIVE)
    else $error("remote wake-up not started");

  chk_wake_refused: assert property (
    wr_strobe && is_cmd(active_cmd, CMD_DEV_STATUS) && !wake_drive
    && (wr_data[BIT_SLEEP] || !idle_sleep_state || !pullup_attached)
    |=> !wake_drive)
    else $error("ignored suspend write started wake-up");

  chk_sleep_enter: assert property (
    sleep_enter && !sleep_leave |=> idle_sleep_state)
    else $error("suspend not entered after idle");

  chk_sleep_exit: assert property (
    activity_sync && idle_sleep_state |=> !idle_sleep_state ##0 sleep_state_changed)
    else $error("suspend not left on activity");

  chk_change_flag: assert property (
    $changed(idle_sleep_state) |-> sleep_state_changed && device_state_event)
    else $error("suspend toggle not flagged");

  chk_event_same: assert property (
    $rose(sleep_state_changed) |-> device_state_event)
    else $error("change flag without device event");

  chk_reset_taken: assert property (
    reset_accept |=> bus_reset_flag && enter_default && device_state_event
    ##1 (enter_default == $past(reset_accept)))
    else $error("bus reset not handled");

  chk_reset_ignored: assert property (
    bus_reset_seen && !pullup_attached |=> !enter_default)
    else $error("bus reset taken while disconnected");

  chk_status_read: assert property (
    status_rd && !reset_accept && (next_sleep == idle_sleep_state)
    |=> rd_done && !bus_reset_flag && !sleep_state_changed
    && rd_data[BIT_BUS_RESET] == $past(bus_reset_flag))
    else $error("status read wrong");

  chk_fault_read: assert property (
    fault_rd |=> rd_done && rd_data[FAULT_CODE_W-1:0] == $past(fault_code))
    else $error("fault read wrong");

  chk_event_clear: assert property (
    status_cmd && !reset_accept && (next_sleep == idle_sleep_state)
    |=> !device_state_event)
    else $error("status command left device event set");

  cov_suspend: cover property (sleep_enter ##[1:20] idle_sleep_state);
  cov_wake: cover property (wake_request ##1 wake_drive);
  cov_reset: cover property (reset_accept ##[1:20] status_rd);
  cov_fault: cover property (fault_strobe ##[1:20] fault_rd);

endmodule

/* File: verif/usb_host_model.sv */
// Upstream host model: bus activity pulses and bus reset signalling
`timescale 1ns/100ps
module usb_host_model (
  input  wire logic core_clk,
  output logic      line_activity,
  output logic      bus_reset_seen
);
  // ----------------------------------------------------------------
  // Activity pattern
  // ----------------------------------------------------------------
  bit   alive = 1'b0;
  int   cnt   = 0;

  initial begin
    line_activity  = 1'b0;
    bus_reset_seen = 1'b0;
  end

  // Traffic every fourth cycle while alive, line idle low otherwise
  always @(negedge core_clk) begin
    cnt <= cnt + 1;
    line_activity <= alive && (cnt % 4 == 0);
  end

  // ----------------------------------------------------------------
  // Bus reset, one cycle long
  // ----------------------------------------------------------------
  task automatic bus_reset();
    @(negedge core_clk);
    bus_reset_seen = 1'b1;
    @(negedge core_clk);
    bus_reset_seen = 1'b0;
  endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the device status and fault block
`timescale 1ns/100ps
module tb_top;
  import usb_status_pkg::*;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  localparam int IDLE_N = 20;
  localparam int WAKE_N = 8;
  logic       core_clk        = 1'b0;
  logic       resetn          = 1'b0;
  logic       cmd_strobe      = 1'b0;
  logic [7:0] cmd_code        = 8'h00;
  logic       wr_strobe       = 1'b0;
  logic [7:0] wr_data         = 8'h00;
  logic       rd_strobe       = 1'b0;
  logic       pullup_attached = 1'b0;
  logic       fault_strobe    = 1'b0;
  logic [3:0] fault_in        = 4'h0;
  logic [7:0] rd_data;
  logic       rd_done;
  logic       line_activity;
  logic       bus_reset_seen;
  logic       idle_sleep_state;
  logic       device_state_event;
  logic       enter_default;
  logic       wake_drive;
  logic [7:0] r;
  int         num_errors      = 0;
  int         checks          = 0;
  int         n_def           = 0;
  int         d0;
  bit         m_con, m_sus, m_chg, m_rst, m_act;
  logic [3:0] m_code          = 4'h0;

  always #25 core_clk = ~core_clk;

  usb_sie_device_status_error #(.IDLE_CYCLES(IDLE_N), .WAKE_CYCLES(WAKE_N)) DUT (
    .core_clk(core_clk), .resetn(resetn), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .rd_done(rd_done), .line_activity(line_activity), .bus_reset_seen(bus_reset_seen),
    .pullup_attached(pullup_attached), .fault_strobe(fault_strobe), .fault_in(fault_in),
    .idle_sleep_state(idle_sleep_state), .device_state_event(device_state_event),
    .enter_default(enter_default), .wake_drive(wake_drive)
  );

  usb_host_model host (
    .core_clk(core_clk), .line_activity(line_activity), .bus_reset_seen(bus_reset_seen)
  );

  always @(posedge core_clk) if (enter_default === 1'b1) n_def <= n_def + 1;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] code, input bit wr, input logic [7:0] wd,
                      output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_strobe = 1'b1;
    cmd_code   = code;
    @(negedge core_clk);
    cmd_strobe = 1'b0;
    wr_strobe  = wr;
    rd_strobe  = !wr;
    wr_data    = wd;
    @(negedge core_clk);
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    while (!wr && rd_done !== 1'b1 && n < 3) begin
      @(negedge core_clk);
      n++;
    end
    if (!wr) check({7'h00, rd_done}, 8'h01, "read answer");
    rd = rd_data;
  endtask

  // Reserved bits 7:5 are masked: their read value is undefined
  task automatic read_status();
    logic [7:0] v;
    xfer(CMD_DEV_STATUS, 1'b0, 8'h00, v);
    check(v & 8'h1f, {3'b000, m_rst, m_chg, m_sus, 1'b0, m_con}, "status");
    check({7'h00, device_state_event}, 8'h00, "event after status");
    m_chg = 1'b0;
    m_rst = 1'b0;
  endtask

  task automatic read_fault();
    logic [7:0] v;
    xfer(CMD_FAULT, 1'b0, 8'h00, v);
    check(v & 8'h1f, {3'b000, m_act, m_code}, "fault");
    m_act = 1'b0;
  endtask

  task automatic put_fault(input logic [3:0] code);
    @(negedge core_clk);
    fault_strobe = 1'b1;
    fault_in     = code;
    @(negedge core_clk);
    fault_strobe = 1'b0;
    m_code = code;
    m_act  = 1'b1;
  endtask

  task automatic wait_sleep(input logic lvl, input int lim);
    int n;
    n = 0;
    while (idle_sleep_state !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check({7'h00, idle_sleep_state}, {7'h00, lvl}, "sleep level");
    m_sus = lvl;
    m_chg = 1'b1;
  endtask

  // Counts cycles of remote wake drive, zero when none starts
  task automatic wake_count(input int exp);
    int n;
    int w;
    n = 0;
    w = 0;
    while (wake_drive !== 1'b1 && w < 4) begin
      @(negedge core_clk);
      w++;
    end
    while (wake_drive === 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    check(8'(n), 8'(exp), "wake length");
  endtask

  task automatic summarize();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(32'h1b05));
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    read_status();
    read_fault();
    xfer(8'($urandom_range(16, 240)), 1'b0, 8'h00, r);
    check(r, 8'h00, "unknown command read");
    pullup_attached = 1'b1;
    host.alive = 1'b1;
    m_con = 1'b1;
    read_status();
    xfer(CMD_DEV_STATUS, 1'b1, 8'h01, r);
    wake_count(0);
    for (int i = 0; i < 16; i++) begin
      put_fault(4'(i));
      repeat ($urandom_range(0, 3)) @(negedge core_clk);
      read_fault();
      read_fault();
    end
    put_fault(4'($urandom_range(0, 15)));
    put_fault(4'($urandom_range(0, 15)));
    read_fault();
    d0 = n_def;
    host.bus_reset();
    repeat (3) @(negedge core_clk);
    check(8'(n_def - d0), 8'h01, "default entry");
    check({7'h00, device_state_event}, 8'h01, "reset event");
    m_rst = 1'b1;
    read_status();
    read_status();
    host.alive = 1'b0;
    repeat (IDLE_N - 4) @(negedge core_clk);
    check({7'h00, idle_sleep_state}, 8'h00, "early sleep");
    wait_sleep(1'b1, 40);
    check({7'h00, device_state_event}, 8'h01, "sleep event");
    read_status();
    xfer(CMD_DEV_STATUS, 1'b1, 8'h05, r);
    wake_count(0);
    xfer(CMD_DEV_STATUS, 1'b1, 8'h01, r);
    wake_count(WAKE_N);
    host.alive = 1'b1;
    wait_sleep(1'b0, 12);
    check({7'h00, device_state_event}, 8'h01, "resume event");
    read_status();
    host.alive = 1'b0;
    wait_sleep(1'b1, IDLE_N + 20);
    read_status();
    pullup_attached = 1'b0;
    m_con = 1'b0;
    wait_sleep(1'b0, 4);
    xfer(CMD_DEV_STATUS, 1'b1, 8'h00, r);
    wake_count(0);
    d0 = n_def;
    host.bus_reset();
    repeat (3) @(negedge core_clk);
    check(8'(n_def - d0), 8'h00, "ignored reset");
    read_status();
    summarize();
  end
endmodule
